/* File: fsl_mn_model.sv */
// Managing node model that issues state commands to the node.
`timescale 1ns/10ps
module fsl_mn_model
   import fsl_pkg::*;
(
   // Clock.
   input  wire logic    ref_clk,
   // Command strobe towards the node.
   output fsl_cmd_bus_t cmdOut
);
   // The idle strobe carries no valid command.
   initial cmdOut = '0;
   // One-cycle pulse; the released code is inverted so no stale code lingers.
   task automatic send(input fsl_cmd_t c);
      @(posedge ref_clk);
      #1 cmdOut = '{valid: 1'b1, code: c};
      @(posedge ref_clk);
      #1 cmdOut = '{valid: 1'b0, code: fsl_cmd_t'(~c)};
   endtask
endmodule // fsl_mn_model

/* File: fsl_pkg.sv */
// Package with states, commands, timing and carrier types for the status LED.
package fsl_pkg;

   // Clock rate of ref_clk in hertz.
   localparam int unsigned CLK_HZ = 40000000;

   // Pattern timing in milliseconds, as printed or chosen.
   localparam int unsigned SHORT_MS = 150;  // Short error pulse.
   localparam int unsigned LONG_MS = 600;   // Long error pulse.
   localparam int unsigned PAUSE_MS = 2000; // Pause after four pulses.
   localparam int unsigned FLASH_MS = 200;  // Flash on/off phase.
   localparam int unsigned FRAME_MS = 1000; // Flash frame, about 1 Hz.
   localparam int unsigned BLINK_MS = 200;  // Half period at 2.5 Hz.
   localparam int unsigned FLICK_MS = 50;   // Half period at 10 Hz.

   // Cycles per millisecond at the clock rate.
   localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;

   // Node state encoding.
   typedef enum logic [2:0] {
      ST_NOT_ACTIVE,
      ST_BASIC_ETH,
      ST_PREOP1,
      ST_PREOP2,
      ST_READY,
      ST_OPERATIONAL,
      ST_STOPPED
   } fsl_state_t;

   // Commands from the managing node, or local events.
   typedef enum logic [2:0] {
      CMD_NONE,
      CMD_GO_BASIC,
      CMD_GO_PREOP1,
      CMD_GO_PREOP2,
      CMD_ENABLE_READY,
      CMD_START,
      CMD_STOP,
      CMD_RESET_NODE
   } fsl_cmd_t;

   // System stop error kinds.
   typedef enum logic [1:0] {
      ERR_NONE,
      ERR_RAM,
      ERR_HW
   } fsl_err_t;

   // Command strobe with its code.
   typedef struct packed {
      logic     valid;
      fsl_cmd_t code;
   } fsl_cmd_bus_t;

   // Data path gating derived from the node state.
   typedef struct packed {
      logic txEnable;      // Transmit process data per mapping.
      logic rxEvaluate;    // Evaluate received cyclic data.
      logic rxDiscard;     // Drop received process data contents.
      logic inputProvide;  // Provide input data to the application.
   } fsl_gate_t;

   // Configuration options.
   typedef struct packed {
      logic ringRedundancy;
      logic pollChaining;
   } fsl_cfg_t;

   // Pulse lengths per error code position; bit set means long pulse.
   localparam logic [3:0] CODE_RAM = 4'h8; // S S S L, first pulse is bit 0.
   localparam logic [3:0] CODE_HW = 4'h9;  // L S S L.
   localparam logic [2:0] NUM_PULSES = 3'h4;

endpackage : fsl_pkg

/* File: fsl_status_led.sv */
// Node state tracker and dual-colour status/error LED sequencer.
//
// Contract
// - Controlled preop2 accepts config, readies on command.
// - Ready state shows triple flash at 1 Hz.
// - Managing node ready discards received process data.
// - Controlled ready transmits mapped data, no evaluation.
// - Red on in preop2/ready when manager failed.
// - Operational: green steady, mapping active, data evaluated.
// - Stopped: green blinks at 2.5 Hz.
// - Managing node never enters stopped.
// - Controlled stopped: no output, no input data.
// - Stopped entered and left only by command.
// - Error code is four short/long red pulses.
// - Code repeats with two-second pause while stopped.
// - Memory fault: short short short long.
// - Hardware fault: long short short long.
// - Reject ring redundancy with chaining together.
// - Green off when inactive, 10 Hz flicker basic.
// - Single flash preop1, double flash preop2.
`timescale 1ns/10ps

module fsl_status_led
   import fsl_pkg::*;
#(
   parameter int unsigned CYC_MS = CYC_PER_MS  // Cycles per millisecond.
)
(
   // Clock and reset.
   input  wire logic         ref_clk,
   input  wire logic         reset,
   // Role and node events.
   input  wire logic         isManaging,     // High when managing node.
   input  wire fsl_cmd_bus_t cmdIn,          // Command strobe.
   input  wire logic         managerFailed,  // Manager loss seen.
   input  wire fsl_err_t     sysErr,         // System stop error level.
   // Configuration request.
   input  wire logic         cfgWrite,       // Configuration write strobe.
   input  wire fsl_cfg_t     cfgIn,          // Requested options.
   output logic              cfgReject,      // Last write was refused.
   output fsl_cfg_t          cfgActive,      // Options in force.
   // Node state and data gating.
   output fsl_state_t        nodeState,
   output fsl_gate_t         dataGate,
   // LED drive, active high.
   output logic              ledGreen,
   output logic              ledRed
);

   // Converts milliseconds to cycles, at least one.
   function automatic logic [31:0] msToCyc(input int unsigned ms);
      int unsigned c;
      c = ms * CYC_MS;
      msToCyc = (c == 0) ? 32'h1 : c[31:0];
   endfunction

   // Node state machine registers.
   fsl_state_t stateReg, stateNext;
   // Configuration registers.
   fsl_cfg_t   cfgReg;
   logic       rejReg;
   // Green pattern timer: phase counter and tick counter.
   logic [31:0] gTickReg;
   logic [3:0]  gPhaseReg;
   // Red error sequencer.
   logic [31:0] rTickReg;
   logic [3:0]  rStepReg;   // Even steps are pulses, odd are gaps.
   logic        rOnReg;
   logic        greenReg;

   // Command decode.
   wire logic     cmdV = cmdIn.valid;
   wire fsl_cmd_t cmd = cmdIn.code;

   // Next-state decode; stopped only via its commands.
   always_comb
   begin
      stateNext = stateReg;
      if (cmdV)
      begin
         case (cmd)
            CMD_RESET_NODE:   stateNext = ST_NOT_ACTIVE;
            CMD_GO_BASIC:
               // A basic Ethernet node is left only by reset when managing.
               if (stateReg == ST_NOT_ACTIVE)
                  stateNext = ST_BASIC_ETH;
            CMD_GO_PREOP1:
               if (stateReg != ST_STOPPED &&
                   !(isManaging && stateReg == ST_BASIC_ETH))
                  stateNext = ST_PREOP1;
            CMD_GO_PREOP2:
               if (stateReg == ST_PREOP1)
                  stateNext = ST_PREOP2;
            CMD_ENABLE_READY:
               if (stateReg == ST_PREOP2)
                  stateNext = ST_READY;
            CMD_START:
               if (stateReg == ST_READY)
                  stateNext = ST_OPERATIONAL;
            CMD_STOP:
               // The managing node has no stopped state.
               if (!isManaging && (stateReg == ST_PREOP2 ||
                   stateReg == ST_READY || stateReg == ST_OPERATIONAL))
                  stateNext = ST_STOPPED;
            default:
               stateNext = stateReg;
         endcase
         // Leaving stopped also needs an explicit command back.
         if (stateReg == ST_STOPPED && cmd == CMD_GO_PREOP2)
            stateNext = ST_PREOP2;
      end
   end

   // State register.
   always_ff @(posedge ref_clk)
   begin
      if (reset)
         stateReg <= ST_NOT_ACTIVE;
      else
         stateReg <= stateNext;
   end

   // Configuration update; the combined option is refused whole.
   wire logic cfgBad = cfgIn.ringRedundancy & cfgIn.pollChaining;
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         cfgReg <= '0;
         rejReg <= 1'b0;
      end
      else if (cfgWrite)
      begin
         rejReg <= cfgBad;
         if (!cfgBad)
            cfgReg <= cfgIn;
      end
   end

   // Data gating from state and role.
   wire logic inReady = (stateReg == ST_READY);
   wire logic inOper = (stateReg == ST_OPERATIONAL);
   wire logic inStop = (stateReg == ST_STOPPED);
   // One driver for the whole carrier, so no field is written twice.
   // Mapping is active in operational for both roles, and in ready only
   // for a controlled node; a stopped node never moves process data.
   assign dataGate = '{
      txEnable:     inOper || (inReady && !isManaging),
      rxEvaluate:   inOper,
      rxDiscard:    (isManaging && inReady) || inStop,
      inputProvide: inOper
   };

   // Green pattern: flashes use phases of FLASH_MS within a FRAME_MS frame.
   // Phases 0, 2, 4 on up to the flash count, odd phases off, then dark to the frame end.
   wire logic [31:0] flashLen = msToCyc(FLASH_MS);
   wire logic [31:0] darkLen =
      msToCyc(FRAME_MS - 5 * FLASH_MS);
   wire logic [3:0] nFlash =
      (stateReg == ST_PREOP1) ? 4'h1 :
      (stateReg == ST_PREOP2) ? 4'h2 : 4'h3;
   wire logic [3:0] lastPhase = 4'h6;
   wire logic [31:0] gLen =
      (stateReg == ST_STOPPED) ? msToCyc(BLINK_MS) :
      (stateReg == ST_BASIC_ETH) ? msToCyc(FLICK_MS) :
      (gPhaseReg == 4'h5) ? darkLen : flashLen;
   wire logic gWrap = (gTickReg + 32'h1 >= gLen);
   wire logic flashing = (stateReg == ST_PREOP1) ||
                         (stateReg == ST_PREOP2) || inReady;
   wire logic flashOn = !gPhaseReg[0] && (gPhaseReg < {nFlash[2:0], 1'b0});
   wire logic toggler = (stateReg == ST_STOPPED) ||
                        (stateReg == ST_BASIC_ETH);

   // Green timer; restarts on any state change so patterns begin cleanly.
   always_ff @(posedge ref_clk)
   begin
      if (reset || stateNext != stateReg)
      begin
         gTickReg <= 32'h0;
         gPhaseReg <= 4'h0;
         greenReg <= 1'b0;
      end
      else
      begin
         gTickReg <= gWrap ? 32'h0 : gTickReg + 32'h1;
         if (gWrap)
         begin
            gPhaseReg <= (toggler || gPhaseReg == lastPhase - 4'h1) ?
                         4'h0 : gPhaseReg + 4'h1;
            greenReg <= toggler ? !greenReg : 1'b0;
         end
      end
   end

   // Green output selection per state.
   assign ledGreen = inOper ? 1'b1 :
                     flashing ? flashOn :
                     toggler ? !greenReg : 1'b0;

   // Red error sequencer: steps 0,2,4,6 pulses, 1,3,5 gaps, 7 pause.
   wire logic [3:0] code = (sysErr == ERR_HW) ? CODE_HW : CODE_RAM;
   wire logic [1:0] pIdx = rStepReg[2:1];
   wire logic isPulse = !rStepReg[0];
   wire logic isPause = (rStepReg == {NUM_PULSES, 1'b0} - 4'h1);
   wire logic [31:0] rLen =
      isPause ? msToCyc(PAUSE_MS) :
      !isPulse ? msToCyc(SHORT_MS) :
      code[pIdx] ? msToCyc(LONG_MS) : msToCyc(SHORT_MS);
   wire logic rWrap = (rTickReg + 32'h1 >= rLen);
   wire logic errOn = (sysErr != ERR_NONE);

   // Error sequence timer, held at the first pulse while no error.
   always_ff @(posedge ref_clk)
   begin
      if (reset || !errOn)
      begin
         rTickReg <= 32'h0;
         rStepReg <= 4'h0;
      end
      else
      begin
         rTickReg <= rWrap ? 32'h0 : rTickReg + 32'h1;
         if (rWrap)
            rStepReg <= isPause ? 4'h0 : rStepReg + 4'h1;
      end
   end

   // Red drive; the error code overrides the manager-failed indication.
   wire logic mgrLost = !isManaging && managerFailed &&
                        (stateReg == ST_PREOP2 || inReady);
   always_ff @(posedge ref_clk)
   begin
      if (reset)
         rOnReg <= 1'b0;
      else
         rOnReg <= errOn ? (isPulse && !isPause) : mgrLost;
   end
   assign ledRed = rOnReg;

   // Status outputs.
   assign nodeState = stateReg;
   assign cfgActive = cfgReg;
   assign cfgReject = rejReg;

endmodule // fsl_status_led

/* File: fsl_status_led_props.sv */
// Checker for the status LED sequencer ports.
`timescale 1ns/10ps
module fsl_status_led_props
   import fsl_pkg::*;
#(
   parameter int unsigned CYC_MS = 4  // Cycles per millisecond.
)
(
   // Clock and reset.
   input wire logic         ref_clk,
   input wire logic         reset,
   // Inputs.
   input wire logic         isManaging,
   input wire fsl_cmd_bus_t cmdIn,
   input wire logic         managerFailed,
   input wire fsl_err_t     sysErr,
   input wire logic         cfgWrite,
   input wire fsl_cfg_t     cfgIn,
   // Outputs.
   input wire logic         cfgReject,
   input wire fsl_cfg_t     cfgActive,
   input wire fsl_state_t   nodeState,
   input wire fsl_gate_t    dataGate,
   input wire logic         ledGreen,
   input wire logic         ledRed
);
   // One clock domain, so one clocking and one disable.
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   // Both options together is the refused combination.
   wire both = cfgIn.ringRedundancy & cfgIn.pollChaining;
   wire ctlFail = nodeState inside {ST_PREOP2, ST_READY} && !isManaging
      && managerFailed && sysErr == ERR_NONE;
   chk_reject_both: assert property (cfgWrite && both |=> cfgReject
      && cfgActive == $past(cfgActive)) else $error("both options taken");
   chk_cfg_take: assert property (cfgWrite && !both |=> !cfgReject
      && cfgActive == $past(cfgIn)) else $error("option write lost");
   chk_oper_steady: assert property (nodeState == ST_OPERATIONAL |->
      ledGreen && dataGate.rxEvaluate && dataGate.txEnable)
      else $error("operational output wrong");
   chk_mn_nostop: assert property ($rose(nodeState == ST_STOPPED)
      |-> !$past(isManaging) && $past(cmdIn.valid)
      && $past(cmdIn.code) == CMD_STOP) else $error("stopped without stop");
   chk_stop_gate: assert property (nodeState == ST_STOPPED |->
      !dataGate.txEnable && !dataGate.inputProvide)
      else $error("stopped node moves data");
   chk_idle_dark: assert property (nodeState == ST_NOT_ACTIVE |->
      !ledGreen) else $error("green lit when inactive");
   chk_ready_gate: assert property (nodeState == ST_READY && !isManaging
      |-> dataGate.txEnable && !dataGate.rxEvaluate)
      else $error("ready gating wrong");
   chk_mn_discard: assert property (nodeState == ST_READY && isManaging
      |-> dataGate.rxDiscard) else $error("manager keeps data");
   chk_red_fail: assert property (ctlFail [*2] |-> ledRed)
      else $error("red dark on manager loss");
endmodule // fsl_status_led_props

/* File: tb_fsl_status_led.sv */
// Self-checking bench for the status LED sequencer.
`timescale 1ns/10ps
module tb_fsl_status_led;
   import fsl_pkg::*;
   localparam int CM = 4;               // Shortened cycles per millisecond.
   localparam int W = FRAME_MS * CM;    // Green count window, one frame.
   localparam int F = FLASH_MS * CM;    // One flash phase.
   localparam int RUN_MAX = 10000;      // Longest red run before giving up.
   logic         ref_clk = 1'b0;
   logic         reset = 1'b1;
   logic         isManaging = 1'b0;
   fsl_cmd_bus_t cmdIn;
   logic         managerFailed = 1'b0;
   fsl_err_t     sysErr = ERR_NONE;
   logic         cfgWrite = 1'b0;
   fsl_cfg_t     cfgIn = '0;
   logic         cfgReject, ledGreen, ledRed;
   fsl_cfg_t     cfgActive, act;
   fsl_state_t   nodeState;
   fsl_gate_t    dataGate;
   int           miscompares = 0;
   int           samples_checked = 0;
   int           k;
   // Command sequence of a controlled node with its states and green time.
   fsl_cmd_t   cs[6] = '{CMD_GO_BASIC, CMD_GO_PREOP1, CMD_GO_PREOP2,
                         CMD_ENABLE_READY, CMD_START, CMD_STOP};
   fsl_state_t ss[6] = '{ST_BASIC_ETH, ST_PREOP1, ST_PREOP2, ST_READY,
                         ST_OPERATIONAL, ST_STOPPED};
   int         gs[6] = '{W / 2, F, 2 * F, 3 * F, W, 3 * BLINK_MS * CM};
   always #12.5 ref_clk = ~ref_clk;
   fsl_mn_model mn_u (.ref_clk(ref_clk), .cmdOut(cmdIn));
   fsl_status_led #(.CYC_MS(CM)) dut_u (.ref_clk(ref_clk), .reset(reset),
      .isManaging(isManaging), .cmdIn(cmdIn), .managerFailed(managerFailed),
      .sysErr(sysErr), .cfgWrite(cfgWrite), .cfgIn(cfgIn),
      .cfgReject(cfgReject), .cfgActive(cfgActive), .nodeState(nodeState),
      .dataGate(dataGate), .ledGreen(ledGreen), .ledRed(ledRed));
   // Prints the verdict and ends the run.
   task automatic complete_run();
      if (miscompares == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // Compares node states.
   task automatic cmpState(input fsl_state_t got, input fsl_state_t exp);
      samples_checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("mismatch %0t state %0d", $time, got);
      end
   endtask
   // Compares levels and counts.
   task automatic cmpVal(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("mismatch %0t value %0d", $time, got);
      end
   endtask
   // Counts lit green cycles over one frame.
   task automatic gcount(output int n);
      n = 0;
      repeat (W)
      begin
         n += (ledGreen === 1'b1);
         @(posedge ref_clk);
         #1;
      end
   endtask
   // Length of the present run of red at level v; a level held for RUN_MAX cycles
   // fails and ends the run, so a dead sequencer cannot stretch the bench.
   task automatic runlen(input logic v, output int n);
      n = 0;
      while (ledRed === v && n < RUN_MAX)
      begin
         n++;
         @(posedge ref_clk);
         #1;
      end
      if (n == RUN_MAX)
      begin
         miscompares++;
         $display("mismatch %0t red level stuck", $time);
         complete_run();
      end
   endtask
   // Expected length of pulse j of a code; bit set means long.
   function automatic int pulse(input logic [3:0] pat, input int j);
      return (pat[j] ? LONG_MS : SHORT_MS) * CM;
   endfunction
   // Syncs on the pause, then measures four pulses, gaps and the pause.
   task automatic errCode(input fsl_err_t e, input logic [3:0] pat);
      int n;
      int i;
      sysErr = e;
      n = 0;
      for (i = 0; i < 8 && n != PAUSE_MS * CM; i++)
      begin
         runlen(1, n);
         runlen(0, n);
      end
      for (i = 0; i < 4; i++)
      begin
         runlen(1, n);
         cmpVal(n, pulse(pat, i));
         runlen(0, n);
         cmpVal(n, (i == 3 ? PAUSE_MS : SHORT_MS) * CM);
      end
   endtask
   // Main sequence: controlled walk, refusals, managing role, error codes.
   initial
   begin
      void'($urandom(32'h0ab3beb2));
      repeat (4) @(posedge ref_clk);
      #1 reset = 1'b0;
      gcount(k);
      cmpVal(k, 0);
      act = '0;
      for (int i = 0; i < 6; i++)
      begin
         mn_u.send(cs[i]);
         cmpState(nodeState, ss[i]);
         gcount(k);
         cmpVal(k, gs[i]);
         // Options and the manager-loss light are tried in pre-op 2.
         if (i == 2)
         begin
            cfgWrite = 1'b1;
            for (int j = 0; j < 12; j++)
            begin
               cfgIn = (j == 0) ? 2'h3 : fsl_cfg_t'(2'($urandom));
               @(posedge ref_clk);
               #1;
               if (cfgIn !== 2'h3)
                  act = cfgIn;
               cmpVal(cfgReject, cfgIn === 2'h3);
               cmpVal(cfgActive, act);
            end
            cfgWrite = 1'b0;
            managerFailed = 1'b1;
            repeat (2) @(posedge ref_clk);
            #1;
            cmpVal(ledRed, 1'b1);
            managerFailed = 1'b0;
         end
      end
      cmpVal(dataGate.txEnable | dataGate.inputProvide, 1'b0);
      mn_u.send(CMD_START);
      cmpState(nodeState, ST_STOPPED);
      mn_u.send(CMD_GO_PREOP2);
      cmpState(nodeState, ST_PREOP2);
      // Second reset in mid-run, leaving the node in the managing role.
      reset = 1'b1;
      isManaging = 1'b1;
      @(posedge ref_clk);
      #1 reset = 1'b0;
      cmpState(nodeState, ST_NOT_ACTIVE);
      mn_u.send(CMD_GO_PREOP1);
      mn_u.send(CMD_GO_PREOP2);
      mn_u.send(CMD_ENABLE_READY);
      mn_u.send(CMD_STOP);
      cmpState(nodeState, ST_READY);
      cmpVal(dataGate.rxDiscard, 1'b1);
      errCode(ERR_RAM, 4'h8);
      errCode(ERR_HW, 4'h9);
      // The node reset command drops any state back to the dark start.
      mn_u.send(CMD_RESET_NODE);
      cmpState(nodeState, ST_NOT_ACTIVE);
      cmpVal(ledGreen, 1'b0);
      complete_run();
   end
endmodule // tb_fsl_status_led
bind fsl_status_led fsl_status_led_props #(.CYC_MS(CYC_MS)) props_u (
   .ref_clk(ref_clk), .reset(reset), .isManaging(isManaging), .cmdIn(cmdIn),
   .managerFailed(managerFailed), .sysErr(sysErr), .cfgWrite(cfgWrite),
   .cfgIn(cfgIn), .cfgReject(cfgReject), .cfgActive(cfgActive),
   .nodeState(nodeState), .dataGate(dataGate), .ledGreen(ledGreen),
   .ledRed(ledRed));
